/* File: include/sdr_regs.svh */
`ifndef SDR_REGS_SVH
`define SDR_REGS_SVH
// Overview of operation
// - chip select low enables the data output driver and wakes the converter
// - after a conversion the converter sleeps while chip select stays high
// - chip select rising disables the data output driver
// - chip select rising during readout abandons it and starts a new conversion
// - data output is high impedance whenever chip select is high
// - in conversion and sleep with select low, output shows conversion status
// - internal serial clock mode drives the clock pin during data output
// - internal serial clock mode enables a weak pull-up on the clock pin
// - clock mode is internal after reset, then sampled from clock pin at select falling edge
// - notch select high uses the internal oscillator with a 50 Hz notch
// - notch select low uses the internal oscillator with a 60 Hz notch
// - a toggling notch select pin becomes the conversion clock, notch f/2560
// - states repeat in order: conversion, sleep, data output
// - the result stays in the static shift register through sleep
// - readout after select low shows the conversion just finished
// - output changes on falling clock edges, sampled on rising edges
// - data output ends after 32 bits or on select rising
// - a new conversion begins automatically when data output ends
// - calibration is folded into every conversion without changing timing
// - modes come from select and clock timing only, no configuration registers
// - word is four status bits, 24 result bits MSB first, four sub bits
// - first bit is active low done flag, second bit always low
// - third bit is polarity, fourth is overrange
// - on the 32nd falling clock edge output goes high for the next conversion
`define SDR_CLK_HZ 20000000
`define SDR_WORD_BITS 32
`define SDR_RESULT_BITS 24
// internal oscillator conversion clock per notch: notch times 2560
`define SDR_NOTCH_DIV 2560
`define SDR_NOTCH50_HZ 50
`define SDR_NOTCH60_HZ 60
// conversion lasts this many conversion clock periods (20480/f_eosc ms, f_eosc in kHz)
`define SDR_CONV_CLKS 20480
// internal serial clock is the conversion clock divided by 8
`define SDR_ISCK_DIV 8
// a notch select pin with no edge for this many cycles is treated as static
`define SDR_EXT_TIMEOUT_CYC 16
`endif

/* File: include/sdr_pkg.sv */
package sdr_pkg;
   typedef enum logic [1:0] {
      SDR_CONV,
      SDR_SLEEP,
      SDR_OUT
   } sdr_state_e;
endpackage

/* File: logic/sdr_sync.sv */
`timescale 1ns/1ps
// three-stage synchroniser; a change counts once stages two and three agree
module sdr_sync (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic din,
   input wire logic init,
   output logic dout
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   ////////////////////////////////////////////////////////////////////////
   // stage one is read only by stage two
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         dout <= 1'b1;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            dout <= s3_reg;
         end
      end
   end
   // init is unused by logic; the reset values above are the constant 1
   logic unused_init;
   assign unused_init = init;
endmodule // sdr_sync

/* File: logic/sdr_adc_ctrl.sv */
`timescale 1ns/1ps
`include "sdr_regs.svh"
module sdr_adc_ctrl
   import sdr_pkg::*;
#(
   parameter int CONV_CLKS = `SDR_CONV_CLKS,
   parameter int EXT_TIMEOUT_CYC = `SDR_EXT_TIMEOUT_CYC
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic cs_n_pin,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   output logic sck_pullup_en,
   output logic sdo_out,
   output logic sdo_oe,
   input wire logic notch_frequency_select,
   input wire logic [23:0] result_data,
   input wire logic polarity_flag,
   input wire logic overrange_flag,
   input wire logic [3:0] sub_lsb_data,
   output logic conv_active,
   output logic cal_strobe,
   output logic sleep_active,
   output logic ext_clock_active
);
   localparam int CLK_HZ = `SDR_CLK_HZ;
   // internal conversion clock half-period, in system cycles
   localparam int HALF50 = CLK_HZ / (`SDR_NOTCH50_HZ * `SDR_NOTCH_DIV * 2);
   localparam int HALF60 = CLK_HZ / (`SDR_NOTCH60_HZ * `SDR_NOTCH_DIV * 2);

   sdr_state_e state_reg;
   logic cs_n_s;
   logic sck_s;
   logic fsel_s;
   logic cs_n_d_reg;
   logic sck_d_reg;
   logic fsel_d_reg;
   logic ext_mode_reg;
   logic int_sck_reg;
   logic [7:0] osc_cnt_reg;
   logic osc_tick;
   logic ext_tick;
   logic [15:0] idle_cnt_reg;
   logic ext_clk_reg;
   logic [2:0] isck_div_reg;
   logic [$clog2(CONV_CLKS+1)-1:0] conv_cnt_reg;
   logic [31:0] shift_reg;
   logic [5:0] bit_cnt_reg;
   logic eoc_n_reg;
   logic cs_fall;
   logic cs_rise;
   logic sck_fall;
   logic conv_tick;
   logic done_word;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   sdr_sync u_cs (.clk_sys(clk_sys), .rstn(rstn), .din(cs_n_pin), .init(1'b1),
      .dout(cs_n_s));
   sdr_sync u_sck (.clk_sys(clk_sys), .rstn(rstn), .din(sck_in), .init(1'b1),
      .dout(sck_s));
   sdr_sync u_fsel (.clk_sys(clk_sys), .rstn(rstn), .din(notch_frequency_select),
      .init(1'b1), .dout(fsel_s));

   // delayed copies for edge detection on synchronised levels
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cs_n_d_reg <= 1'b1;
         sck_d_reg <= 1'b1;
         fsel_d_reg <= 1'b1;
      end else begin
         cs_n_d_reg <= cs_n_s;
         sck_d_reg <= sck_s;
         fsel_d_reg <= fsel_s;
      end
   end
   assign cs_fall = cs_n_d_reg & ~cs_n_s;
   assign cs_rise = ~cs_n_d_reg & cs_n_s;

   ////////////////////////////////////////////////////////////////////////
   // external conversion clock detection: any recent toggle on the pin
   assign ext_tick = fsel_s & ~fsel_d_reg;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         idle_cnt_reg <= 16'h0000;
         ext_clk_reg <= 1'b0;
      end else if (fsel_s != fsel_d_reg) begin
         idle_cnt_reg <= 16'h0000;
         ext_clk_reg <= 1'b1;
      end else if (idle_cnt_reg >= 16'(EXT_TIMEOUT_CYC)) begin
         ext_clk_reg <= 1'b0; // static level: back to internal oscillator
      end else begin
         idle_cnt_reg <= idle_cnt_reg + 16'h0001;
      end
   end
   assign ext_clock_active = ext_clk_reg;

   // internal oscillator tick; rate follows notch select level
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         osc_cnt_reg <= 8'h00;
      end else if (osc_tick) begin
         osc_cnt_reg <= 8'h00;
      end else begin
         osc_cnt_reg <= osc_cnt_reg + 8'h01;
      end
   end
   // high picks the 50 Hz notch, low the 60 Hz notch; full period = 2 halves
   assign osc_tick = fsel_s ? (osc_cnt_reg == 8'(2*HALF50 - 1))
                            : (osc_cnt_reg == 8'(2*HALF60 - 1));
   // one enable pulse per conversion clock period from whichever source is live
   assign conv_tick = ext_clk_reg ? ext_tick : osc_tick;

   ////////////////////////////////////////////////////////////////////////
   // serial clock mode: internal after reset, sampled from the clock pin at cs fall
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ext_mode_reg <= 1'b0;
      end else if (cs_fall) begin
         ext_mode_reg <= ~sck_s;
      end
   end
   assign sck_pullup_en = ~ext_mode_reg;

   ////////////////////////////////////////////////////////////////////////
   // main sequencer
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_reg <= SDR_CONV;
      end else begin
         unique case (state_reg)
            SDR_CONV: begin
               if (conv_tick && conv_cnt_reg == ($bits(conv_cnt_reg))'(CONV_CLKS - 1)) begin
                  state_reg <= SDR_SLEEP;
               end
            end
            SDR_SLEEP: begin
               if (!cs_n_s) begin
                  state_reg <= SDR_OUT;
               end
            end
            SDR_OUT: begin
               if (cs_rise || done_word) begin
                  state_reg <= SDR_CONV;
               end
            end
         endcase
      end
   end
   assign conv_active = (state_reg == SDR_CONV);
   assign sleep_active = (state_reg == SDR_SLEEP);

   // conversion length counter; calibration is pulsed inside the same window
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         conv_cnt_reg <= '0;
      end else if (state_reg != SDR_CONV) begin
         conv_cnt_reg <= '0;
      end else if (conv_tick) begin
         conv_cnt_reg <= conv_cnt_reg + 1'b1;
      end
   end
   // calibration hook at conversion start; timing seen outside is unchanged
   assign cal_strobe = conv_active && conv_tick && (conv_cnt_reg == '0);

   ////////////////////////////////////////////////////////////////////////
   // internal serial clock: conversion clock divided by 8, only in data output
   // idles low so the first edge after select falls is a rise: bit 31 is
   // taken there, and no fall can shift it away before the host samples it
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         isck_div_reg <= 3'h0;
         int_sck_reg <= 1'b0;
      end else if (state_reg != SDR_OUT || ext_mode_reg) begin
         isck_div_reg <= 3'h0;
         int_sck_reg <= 1'b0;
      end else if (conv_tick) begin
         isck_div_reg <= isck_div_reg + 3'h1;
         if (isck_div_reg == 3'(`SDR_ISCK_DIV/2 - 1) || isck_div_reg == 3'(`SDR_ISCK_DIV - 1)) begin
            int_sck_reg <= ~int_sck_reg;
         end
      end
   end
   // clock pin is driven only in internal mode during data output
   assign sck_oe = ~ext_mode_reg && (state_reg == SDR_OUT) && !cs_n_s;
   assign sck_out = int_sck_reg;

   // falling edge of whichever serial clock is active
   assign sck_fall = ext_mode_reg ? (sck_d_reg & ~sck_s)
                                  : (conv_tick && int_sck_reg &&
                                     (isck_div_reg == 3'(`SDR_ISCK_DIV - 1)) &&
                                     state_reg == SDR_OUT);
   assign done_word = sck_fall && (bit_cnt_reg == 6'(`SDR_WORD_BITS - 1));

   ////////////////////////////////////////////////////////////////////////
   // done flag: high while converting, low once result is latched
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         eoc_n_reg <= 1'b1;
      end else if (state_reg == SDR_CONV && conv_tick &&
                   conv_cnt_reg == ($bits(conv_cnt_reg))'(CONV_CLKS - 1)) begin
         eoc_n_reg <= 1'b0;
      end else if (state_reg == SDR_OUT && (cs_rise || done_word)) begin
         eoc_n_reg <= 1'b1;
      end
   end

   // output word is loaded at end of conversion and held through sleep
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         shift_reg <= 32'h0000_0000;
         bit_cnt_reg <= 6'h00;
      end else if (state_reg == SDR_CONV && conv_tick &&
                   conv_cnt_reg == ($bits(conv_cnt_reg))'(CONV_CLKS - 1)) begin
         // eoc low, filler low, polarity, overrange, result, sub bits
         shift_reg <= {1'b0, 1'b0, polarity_flag, overrange_flag,
                       result_data, sub_lsb_data};
         bit_cnt_reg <= 6'h00;
      end else if (state_reg == SDR_OUT && sck_fall && !done_word) begin
         shift_reg <= {shift_reg[30:0], 1'b0};
         bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end else if (state_reg != SDR_OUT) begin
         bit_cnt_reg <= 6'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data pin drive; status shown outside data output, released when cs high
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sdo_oe <= 1'b0;
         sdo_out <= 1'b1;
      end else begin
         sdo_oe <= ~cs_n_s;
         if (state_reg == SDR_OUT && !done_word) begin
            sdo_out <= shift_reg[31];
         end else if (state_reg == SDR_OUT) begin
            sdo_out <= 1'b1;
         end else begin
            sdo_out <= eoc_n_reg;
         end
      end
   end
endmodule // sdr_adc_ctrl

/* File: testbench/sdr_adc_ctrl_props.sv */
`timescale 1ns/1ps
module sdr_adc_ctrl_props #(
   parameter int EXT_TIMEOUT_CYC = 16
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic cs_n_pin,
   input wire logic notch_frequency_select,
   input wire logic sck_oe,
   input wire logic sck_pullup_en,
   input wire logic sdo_out,
   input wire logic sdo_oe,
   input wire logic conv_active,
   input wire logic sleep_active,
   input wire logic ext_clock_active
);
   // margin covers the pin synchroniser and the detector register
   localparam int QUIET = EXT_TIMEOUT_CYC + 8;
   logic notch_q;
   logic [7:0] quiet_cnt;
   // cycles since the notch pin last moved, saturating
   always_ff @(posedge clk_sys) begin
      notch_q <= notch_frequency_select;
      if (!rstn || notch_q != notch_frequency_select) quiet_cnt <= 8'h00;
      else if (quiet_cnt != 8'hff) quiet_cnt <= quiet_cnt + 8'h01;
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_cs_high; cs_n_pin [*6]; endsequence
   sequence s_cs_low; !cs_n_pin [*6]; endsequence
   property p_hiz; s_cs_high |-> !sdo_oe; endproperty
   property p_drive; s_cs_low |-> sdo_oe; endproperty
   property p_abort; $rose(cs_n_pin) && !conv_active && !sleep_active |-> ##[1:8] conv_active;
   endproperty
   property p_sleep; s_cs_high ##0 sleep_active |=> sleep_active; endproperty
   property p_order; $rose(sleep_active) |-> $past(conv_active); endproperty
   property p_pullup; sck_oe |-> sck_pullup_en; endproperty
   property p_status; conv_active [*4] ##0 sdo_oe |-> sdo_out; endproperty
   property p_quiet; quiet_cnt >= QUIET |-> !ext_clock_active; endproperty
   a_hiz: assert property (p_hiz) else $error("data driver on with select high");
   a_drive: assert property (p_drive) else $error("data driver off with select low");
   a_abort: assert property (p_abort) else $error("no new conversion after abort");
   a_sleep: assert property (p_sleep) else $error("left sleep with select high");
   a_order: assert property (p_order) else $error("sleep not after conversion");
   a_pullup: assert property (p_pullup) else $error("clock driven without pull-up");
   a_status: assert property (p_status) else $error("status bit low in conversion");
   a_quiet: assert property (p_quiet) else $error("external clock seen on idle pin");
endmodule // sdr_adc_ctrl_props
bind sdr_adc_ctrl sdr_adc_ctrl_props #(.EXT_TIMEOUT_CYC(EXT_TIMEOUT_CYC)) i_sdr_adc_ctrl_props (
   .clk_sys(clk_sys), .rstn(rstn), .cs_n_pin(cs_n_pin),
   .notch_frequency_select(notch_frequency_select), .sck_oe(sck_oe),
   .sck_pullup_en(sck_pullup_en), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
   .conv_active(conv_active), .sleep_active(sleep_active), .ext_clock_active(ext_clock_active));

/* File: testbench/sdr_host_model.sv */
`timescale 1ns/1ps
module sdr_host_model (
   input wire logic clk_sys,
   input wire logic sdo_w,
   input wire logic sck_w,
   output logic cs_n,
   output logic sck_drv,
   output logic sck_drv_en
);
   // idle: deselected, clock line released
   initial begin
      cs_n = 1'b1;
      sck_drv = 1'b0;
      sck_drv_en = 1'b0;
   end
   // clock level before select falls picks the mode; held two cycles so the
   // synchronised select edge still sees it, released before the device drives
   task open_frame(input logic ext);
      @(posedge clk_sys);
      sck_drv_en <= 1'b1;
      sck_drv <= ~ext;
      repeat (8) @(posedge clk_sys);
      cs_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      sck_drv_en <= ext;
      repeat (6) @(posedge clk_sys);
   endtask
   // external clock: bit taken as the clock rises, then the clock falls
   task shift_ext(input int n, output logic [31:0] w);
      w = 32'h0000_0000;
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         sck_drv <= 1'b1;
         w = {w[30:0], sdo_w};
         repeat (6) @(posedge clk_sys);
         sck_drv <= 1'b0;
         repeat (6) @(posedge clk_sys);
      end
   endtask
   // internal clock: bit taken on each rise of the device's clock
   task shift_int(input int n, output logic [31:0] w, output logic ok);
      int t;
      logic prv;
      w = 32'h0000_0000;
      ok = 1'b1;
      for (int i = 0; i < n; i++) begin
         t = 0;
         do begin
            prv = sck_w;
            @(posedge clk_sys);
            t++;
         end while (!(sck_w && !prv) && t < 4000);
         if (t >= 4000) begin
            ok = 1'b0;
            return;
         end
         w = {w[30:0], sdo_w};
      end
   endtask
   // raising select early cuts the word short
   task close_frame;
      @(posedge clk_sys);
      cs_n <= 1'b1;
      sck_drv_en <= 1'b0;
   endtask
endmodule // sdr_host_model

/* File: testbench/sdr_adc_ctrl_tb.sv */
`timescale 1ns/1ps
module sdr_adc_ctrl_tb;
   logic clk_sys = 1'b0, rstn = 1'b0, notch = 1'b1, flt = 1'b0, pol = 1'b1, ovr = 1'b0;
   logic [23:0] res = 24'ha5_3c96;
   logic [3:0] sub = 4'h9;
   logic [31:0] w;
   logic ok, sck_w, sdo_w;
   logic cs_n, sck_drv, sck_drv_en, sck_out, sck_oe, pull, sdo_out, sdo_oe;
   logic conv, slp, extc;
   int errors = 0;
   int n_compared = 0;
   always #25 clk_sys = ~clk_sys;
   // released lines toggle so a stale level cannot pass for data
   always @(posedge clk_sys) flt <= ~flt;
   assign sck_w = sck_oe ? sck_out : (sck_drv_en ? sck_drv : (pull ? 1'b1 : flt));
   assign sdo_w = sdo_oe ? sdo_out : flt;
   sdr_host_model i_sdr_host_model (.clk_sys(clk_sys), .sdo_w(sdo_w), .sck_w(sck_w),
      .cs_n(cs_n), .sck_drv(sck_drv), .sck_drv_en(sck_drv_en));
   sdr_adc_ctrl #(.CONV_CLKS(4)) i_sdr_adc_ctrl (.clk_sys(clk_sys), .rstn(rstn),
      .cs_n_pin(cs_n), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
      .sck_pullup_en(pull), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
      .notch_frequency_select(notch), .result_data(res), .polarity_flag(pol),
      .overrange_flag(ovr), .sub_lsb_data(sub), .conv_active(conv), .cal_strobe(),
      .sleep_active(slp), .ext_clock_active(extc));
   ////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task close_out;
      if (errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task wait_sleep;
      int t;
      t = 0;
      while (slp !== 1'b1 && t < 5000) begin
         @(posedge clk_sys);
         t++;
      end
      if (t >= 5000) begin
         errors++;
         close_out;
      end
   endtask
   task set_in(input logic [23:0] r, input logic p, input logic o, input logic [3:0] s);
      @(posedge clk_sys);
      res <= r;
      pol <= p;
      ovr <= o;
      sub <= s;
   endtask
   task t_ext_read;
      wait_sleep;
      repeat (50) @(posedge clk_sys);
      check(slp, 1'b1);
      i_sdr_host_model.open_frame(1'b1);
      i_sdr_host_model.shift_ext(32, w);
      check(w, {2'b00, pol, ovr, res, sub});
      repeat (4) @(posedge clk_sys);
      check(sdo_out, 1'b1);
      check(conv, 1'b1);
      i_sdr_host_model.close_frame;
      repeat (8) @(posedge clk_sys);
      check(sdo_oe, 1'b0);
   endtask
   task t_abort;
      set_in(24'h00_0ff0, 1'b0, 1'b1, 4'h0);
      wait_sleep;
      i_sdr_host_model.open_frame(1'b1);
      i_sdr_host_model.shift_ext(8, w);
      check(w, 32'h0000_0010);
      i_sdr_host_model.close_frame;
      repeat (8) @(posedge clk_sys);
      check(sdo_oe, 1'b0);
      check(conv, 1'b1);
   endtask
   // select low during conversion shows the busy flag, then its fall
   task t_status;
      int t;
      i_sdr_host_model.open_frame(1'b1);
      check(conv, 1'b1);
      check(sdo_oe, 1'b1);
      check(sdo_out, 1'b1);
      for (t = 0; t < 5000 && sdo_out !== 1'b0; t++) @(posedge clk_sys);
      check(sdo_out, 1'b0);
      if (t >= 5000) close_out;
      i_sdr_host_model.close_frame;
      repeat (8) @(posedge clk_sys);
   endtask
   task t_notch;
      for (int i = 0; i < 24; i++) begin
         @(posedge clk_sys);
         notch <= ~notch;
         repeat (3) @(posedge clk_sys);
      end
      check(extc, 1'b1);
      notch <= 1'b1;
      repeat (40) @(posedge clk_sys);
      check(extc, 1'b0);
   endtask
   // internal clock read with the 60 Hz setting
   task t_int_read;
      notch <= 1'b0;
      set_in(24'h5a_c3e1, 1'b1, 1'b1, 4'h6);
      // the held result predates the new inputs: cut it to force a fresh conversion
      i_sdr_host_model.open_frame(1'b1);
      i_sdr_host_model.close_frame;
      repeat (8) @(posedge clk_sys);
      check(conv, 1'b1);
      wait_sleep;
      i_sdr_host_model.open_frame(1'b0);
      check(pull, 1'b1);
      i_sdr_host_model.shift_int(32, w, ok);
      check(ok, 1'b1);
      check(w, {2'b00, pol, ovr, res, sub});
      i_sdr_host_model.close_frame;
      repeat (8) @(posedge clk_sys);
   endtask
   // main sequence; reset held for three cycles, the synchroniser depth
   initial begin
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      #1;
      check({sdo_oe, sck_oe, pull, conv}, 32'h0000_0003);
      t_ext_read;
      t_abort;
      t_status;
      t_notch;
      t_int_read;
      close_out;
   end
endmodule // sdr_adc_ctrl_tb
